// >>> inc/bmpm_pkg.sv
// Package of constants and types for the boot mode pin multiplexer
package bmpm_pkg;

    // ************
    // Bus widths
    // ************
    localparam int ADDR_W      = 14;   // Full memory mode address outputs
    localparam int DATA_W      = 24;   // Full memory mode data pins
    localparam int HOST_W      = 16;   // Host port address/data width
    localparam int BYTE_HI_W   = 8;    // Upper byte address bits on data MSBs
    localparam int NUM_FLAGS   = 8;    // Programmable flag pins 0..7

    // ************
    // Field positions
    // ************
    localparam int FLAG_HOST_SEL = 2;  // Strap on flag 2 selects host mode
    localparam int FLAG_IRQ_EL   = 7;  // Edge or level interrupt pin
    localparam int FLAG_IRQ_LB   = 6;  // Level interrupt b pin
    localparam int FLAG_IRQ_LA   = 5;  // Level interrupt a pin
    localparam int FLAG_IRQ_E    = 4;  // Edge interrupt pin
    localparam int NUM_IRQ       = 6;  // Interrupt request vector width
    localparam int IRQ_SP_A      = 4;  // Serial port interrupt a position
    localparam int IRQ_SP_B      = 5;  // Serial port interrupt b position

    // ************
    // Reset values
    // ************
    localparam logic [2:0]  RST_MODE = 3'h0;    // Mode latches after reset
    localparam logic [23:0] RST_DATA = 24'h000000; // Idle data value

    // ************
    // Modes
    // ************
    typedef enum logic {BMPM_FULL_MEM, BMPM_HOST} bmpm_mode_t;

endpackage

// >>> src/bmpm_edge_det.sv
// Edge or level interrupt detector for one active-low pin
`timescale 1ns/10ps
module bmpm_edge_det (
    input  wire logic mclk_in,       // Processor clock
    input  wire logic reset_in,      // Synchronous reset, high
    input  wire logic pin_n_in,      // Active-low pin level
    input  wire logic edge_mode_in,  // 1 = edge, 0 = level
    input  wire logic clear_in,      // Clears latched edge
    output logic      req_out        // Registered request
);

    // ************
    // State
    // ************
    typedef struct packed {
        logic prev;   // Previous pin level
        logic latch;  // Latched falling edge
        logic req;    // Registered request
    } bmpm_ed_t;

    bmpm_ed_t st_r;   // Current state
    bmpm_ed_t st_nxt; // Next state

    // Next state: edge set wins over clear
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = pin_n_in;
        if (clear_in) begin
            st_nxt.latch = 1'b0;
        end
        if (st_r.prev && !pin_n_in) begin
            st_nxt.latch = 1'b1;
        end
        st_nxt.req = edge_mode_in ? st_nxt.latch : !pin_n_in;
    end

    // Register the state
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st_r <= '{prev: 1'b1, latch: 1'b0, req: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_out = st_r.req;

endmodule

// >>> src/bmpm_pin_mux.sv
// Boot mode strapping and pin multiplexing for the DSP pins
`timescale 1ns/10ps
module bmpm_pin_mux (
    input  wire logic        mclk_in,                 // Processor clock
    input  wire logic        reset_in,                // Master reset, high
    // Core side memory interface
    input  wire logic [13:0] core_addr_in,            // Core external address
    input  wire logic [23:0] core_wdata_in,           // Core write data
    input  wire logic        core_write_in,           // Core drives data
    input  wire logic        core_byte_in,            // Byte memory access
    input  wire logic [7:0]  core_byte_hi_in,         // Upper byte address bits
    output logic [23:0]      core_rdata_out,          // Data sampled from pins
    // External memory pins
    output logic [13:0]      addr_out,                // Address pins
    output logic [23:0]      data_out,                // Data pin drive value
    output logic [23:0]      data_oe_n_out,           // Data enables, low = drive
    input  wire logic [23:0] data_in,                 // Data pin level
    // Host port pins
    input  wire logic [15:0] host_addr_data_bus_in,   // Host bus level
    output logic [15:0]      host_addr_data_bus_out,  // Host bus drive value
    output logic             host_addr_data_bus_oe_n_out, // Low = drive
    input  wire logic        host_write_strobe_n_in,  // Host write, low
    input  wire logic        host_read_strobe_n_in,   // Host read, low
    input  wire logic        host_addr_latch_in,      // Host address latch, high
    input  wire logic        host_port_select_n_in,   // Host select, low
    output logic             host_port_ack_n_out,     // Acknowledge, low
    // Host port core side
    input  wire logic [15:0] host_rdata_in,           // Core read data for host
    input  wire logic        host_ready_in,           // Core ready for host
    output logic [15:0]      host_addr_out,           // Latched host address
    output logic [15:0]      host_wdata_out,          // Host write data
    output logic             host_wr_out,             // Host write pulse
    output logic             host_rd_out,             // Host read pulse
    // Flags and interrupts
    input  wire logic [7:0]  prog_flag_in,            // Flag pin levels
    input  wire logic [7:0]  flag_dir_in,             // 1 = flag is output
    input  wire logic [7:0]  flag_val_in,             // Flag output values
    output logic [7:0]       prog_flag_out,           // Flag drive values
    output logic [7:0]       prog_flag_oe_n_out,      // Low = drive
    output logic [7:0]       flag_read_out,           // Flag input readback
    input  wire logic        irq_el_edge_in,          // Edge mode for pin 7
    input  wire logic [5:0]  interrupt_mask_bits_in,  // Interrupt enables
    input  wire logic [5:0]  irq_clear_in,            // Clear edge latches
    output logic [5:0]       irq_req_out,             // Masked requests
    // Serial port b pins
    input  wire logic        sport_b_irq_mode_in,     // 1 = irq/flag use
    input  wire logic [1:0]  sp_irq_edge_in,          // Edge mode per sp irq
    input  wire logic        sp_rfs_n_in,             // Receive frame / irq a
    input  wire logic        sp_tfs_n_in,             // Transmit frame / irq b
    input  wire logic        sp_dr_in,                // Receive data / flag in
    input  wire logic        core_dt_in,              // Core transmit data
    input  wire logic        core_flag_output_in,     // Core flag out value
    output logic             sp_dt_out,               // Transmit data / flag out
    output logic             flag_input_out,          // Flag input readback
    output logic             sp_rfs_core_out,         // Frame to serial core
    output logic             sp_tfs_core_out,         // Frame to serial core
    output logic             sp_dr_core_out,          // Data to serial core
    // Bus arbitration and power down
    input  wire logic        bus_request_n_in,        // Bus request, low
    input  wire logic        core_bus_idle_in,        // Core may release bus
    output logic             bus_grant_n_out,         // Bus grant, low
    output logic             bus_grant_hung_n_out,    // Grant hung, low
    input  wire logic        power_down_request_n_in, // Power-down, low
    input  wire logic        core_pd_done_in,         // Core entered power-down
    output logic             power_down_ack_out,      // Power-down ack, high
    output logic             host_mode_out            // Latched mode, 1 = host
);

    // ************
    // State
    // ************
    typedef struct packed {
        bmpm_pkg::bmpm_mode_t mode;      // Latched operating mode
        logic [2:0]  straps;             // Latched strap pins
        logic        in_reset;           // Previous cycle was reset
        logic [13:0] addr;               // Address pins
        logic [23:0] data;               // Data drive
        logic [23:0] data_oe_n;          // Data enables
        logic [23:0] rdata;              // Sampled data
        logic [15:0] haddr;              // Latched host address
        logic [15:0] hwdata;             // Host write data
        logic [15:0] hbus;               // Host bus drive value
        logic        hbus_oe_n;          // Host bus enable
        logic        hwr;                // Host write pulse
        logic        hrd;                // Host read pulse
        logic        hack_n;             // Host acknowledge
        logic        hstrobe_d;          // Previous strobe active
        logic [7:0]  pf;                 // Flag drive values
        logic [7:0]  pf_oe_n;            // Flag enables
        logic [7:0]  pf_rd;              // Flag readback
        logic [5:0]  irq;                // Masked requests
        logic        dt;                 // Transmit / flag out
        logic        fi;                 // Flag input
        logic        rfs;                // Frame to serial
        logic        tfs;                // Frame to serial
        logic        dr;                 // Data to serial
        logic        bg_n;               // Bus grant
        logic        bgh_n;              // Grant hung
        logic        pd_ack;             // Power-down ack
    } bmpm_st_t;

    bmpm_st_t   st_r;     // Current state
    bmpm_st_t   st_nxt;   // Next state
    logic [5:0] raw_irq;  // Unmasked interrupt requests
    logic [5:0] pin_n;    // Active-low interrupt pin levels
    logic [5:0] edge_md;  // Edge mode per interrupt

    // ************
    // Interrupt detection
    // ************
    // Flag outputs loop back through the pin level, so flags 4 to 7 driven low request
    always_comb begin
        pin_n   = {sp_tfs_n_in, sp_rfs_n_in,
                   prog_flag_in[bmpm_pkg::FLAG_IRQ_EL], prog_flag_in[bmpm_pkg::FLAG_IRQ_LB],
                   prog_flag_in[bmpm_pkg::FLAG_IRQ_LA], prog_flag_in[bmpm_pkg::FLAG_IRQ_E]};
        // Bits: 0 edge, 1 level a, 2 level b, 3 edge/level, 4-5 serial
        edge_md = {sp_irq_edge_in, irq_el_edge_in, 1'b0, 1'b0, 1'b1};
    end

    // One detector per interrupt source
    for (genvar i = 0; i < bmpm_pkg::NUM_IRQ; i++) begin : g_irq
        bmpm_edge_det u_det (
            .mclk_in      (mclk_in),
            .reset_in     (reset_in),
            .pin_n_in     (pin_n[i]),
            .edge_mode_in (edge_md[i]),
            .clear_in     (irq_clear_in[i]),
            .req_out      (raw_irq[i])
        );
    end

    // ************
    // Next state
    // ************
    always_comb begin
        st_nxt = st_r;
        st_nxt.in_reset = 1'b0;
        st_nxt.hwr = 1'b0;
        st_nxt.hrd = 1'b0;
        // Straps latched on the first cycle after reset release
        if (st_r.in_reset) begin
            st_nxt.straps = prog_flag_in[2:0];
            st_nxt.mode = st_nxt.straps[bmpm_pkg::FLAG_HOST_SEL] ?
                          bmpm_pkg::BMPM_HOST : bmpm_pkg::BMPM_FULL_MEM;
        end
        // Flags are general I/O after reset; straps only read above
        st_nxt.pf      = flag_val_in;
        st_nxt.pf_oe_n = ~flag_dir_in;
        st_nxt.pf_rd   = prog_flag_in;
        // Unmasked requests reach the core
        st_nxt.irq = raw_irq & interrupt_mask_bits_in;
        if (!sport_b_irq_mode_in) begin
            st_nxt.irq[bmpm_pkg::IRQ_SP_B:bmpm_pkg::IRQ_SP_A] = 2'h0; // Pins serve serial
        end
        // Serial port b pins: serial or irq/flag use
        st_nxt.dt  = sport_b_irq_mode_in ? core_flag_output_in : core_dt_in;
        st_nxt.fi  = sport_b_irq_mode_in ? sp_dr_in : 1'b0;
        st_nxt.rfs = sport_b_irq_mode_in ? 1'b1 : sp_rfs_n_in;
        st_nxt.tfs = sport_b_irq_mode_in ? 1'b1 : sp_tfs_n_in;
        st_nxt.dr  = sport_b_irq_mode_in ? 1'b0 : sp_dr_in;
        // Grant once the core is idle; hung while core still needs bus
        st_nxt.bg_n  = !(!bus_request_n_in && core_bus_idle_in);
        st_nxt.bgh_n = !(!st_r.bg_n && !core_bus_idle_in);
        // Power-down acknowledged after the core has stopped
        st_nxt.pd_ack = !power_down_request_n_in && core_pd_done_in;
        st_nxt.rdata = data_in;
        if (st_r.mode == bmpm_pkg::BMPM_FULL_MEM) begin
            // Full memory mode: whole address and data buses
            st_nxt.addr = core_addr_in;
            st_nxt.data = core_wdata_in;
            st_nxt.data_oe_n = core_write_in ? 24'h000000 : 24'hFFFFFF;
            if (core_byte_in) begin
                st_nxt.data[23:16] = core_byte_hi_in; // Byte address on MSBs
                st_nxt.data_oe_n[23:16] = 8'h00;
            end
            st_nxt.hbus_oe_n = 1'b1;
            st_nxt.hack_n = 1'b1;
        end else begin
            // Host mode: only lowest address bit remains
            st_nxt.addr = {13'h0000, core_addr_in[0]};
            // Upper 16 data pins only
            st_nxt.data = {core_wdata_in[23:8], 8'h00};
            st_nxt.data_oe_n = {{16{!core_write_in}}, 8'hFF};
            st_nxt.rdata[7:0] = 8'h00;
            // Address then data on the shared host bus
            if (host_addr_latch_in && !host_port_select_n_in) begin
                st_nxt.haddr = host_addr_data_bus_in;
            end
            st_nxt.hstrobe_d = !host_port_select_n_in &&
                               (!host_write_strobe_n_in || !host_read_strobe_n_in);
            if (st_nxt.hstrobe_d && !st_r.hstrobe_d) begin
                st_nxt.hwr = !host_write_strobe_n_in;
                st_nxt.hrd = !host_read_strobe_n_in;
                if (!host_write_strobe_n_in) begin
                    st_nxt.hwdata = host_addr_data_bus_in;
                end
            end
            st_nxt.hbus = host_rdata_in;
            st_nxt.hbus_oe_n = !(!host_port_select_n_in && !host_read_strobe_n_in);
            st_nxt.hack_n = !(st_nxt.hstrobe_d && host_ready_in);
        end
    end

    // ************
    // Registers
    // ************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st_r <= '0;
            st_r.mode <= bmpm_pkg::BMPM_FULL_MEM;
            st_r.straps <= bmpm_pkg::RST_MODE;
            st_r.in_reset <= 1'b1;
            st_r.data_oe_n <= 24'hFFFFFF;
            st_r.hbus_oe_n <= 1'b1;
            st_r.hack_n <= 1'b1;
            st_r.pf_oe_n <= 8'hFF;
            st_r.rfs <= 1'b1;
            st_r.tfs <= 1'b1;
            st_r.bg_n <= 1'b1;
            st_r.bgh_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************
    // Outputs
    // ************
    assign core_rdata_out = st_r.rdata;
    assign addr_out = st_r.addr;
    assign data_out = st_r.data;
    assign data_oe_n_out = st_r.data_oe_n;
    assign host_addr_data_bus_out = st_r.hbus;
    assign host_addr_data_bus_oe_n_out = st_r.hbus_oe_n;
    assign host_port_ack_n_out = st_r.hack_n;
    assign host_addr_out = st_r.haddr;
    assign host_wdata_out = st_r.hwdata;
    assign host_wr_out = st_r.hwr;
    assign host_rd_out = st_r.hrd;
    assign prog_flag_out = st_r.pf;
    assign prog_flag_oe_n_out = st_r.pf_oe_n;
    assign flag_read_out = st_r.pf_rd;
    assign irq_req_out = st_r.irq;
    assign sp_dt_out = st_r.dt;
    assign flag_input_out = st_r.fi;
    assign sp_rfs_core_out = st_r.rfs;
    assign sp_tfs_core_out = st_r.tfs;
    assign sp_dr_core_out = st_r.dr;
    assign bus_grant_n_out = st_r.bg_n;
    assign bus_grant_hung_n_out = st_r.bgh_n;
    assign power_down_ack_out = st_r.pd_ack;
    assign host_mode_out = st_r.mode;

endmodule

// >>> tb/bmpm_pin_mux_assertions.sv
// Port-level assertion checker for the boot mode pin multiplexer
`timescale 1ns/10ps
module bmpm_pin_mux_assertions (
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic [13:0] core_addr_in,
    input wire logic        core_byte_in,
    input wire logic [7:0]  core_byte_hi_in,
    input wire logic [13:0] addr_out,
    input wire logic [23:0] data_out,
    input wire logic [23:0] data_oe_n_out,
    input wire logic        host_port_ack_n_out,
    input wire logic [7:0]  flag_dir_in,
    input wire logic [7:0]  prog_flag_oe_n_out,
    input wire logic [7:0]  prog_flag_in,
    input wire logic [5:0]  interrupt_mask_bits_in,
    input wire logic [5:0]  irq_req_out,
    input wire logic        bus_request_n_in,
    input wire logic        core_bus_idle_in,
    input wire logic        bus_grant_n_out,
    input wire logic        power_down_request_n_in,
    input wire logic        core_pd_done_in,
    input wire logic        power_down_ack_out,
    input wire logic        host_mode_out
);
    // ************
    // One clock domain, reset disables all checks
    // ************
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    chk_mode_fixed: assert property (!$past(reset_in) && !$past(reset_in, 2) |->
        $stable(host_mode_out)) else $error("mode changed while running");
    chk_host_addr: assert property (host_mode_out && $past(host_mode_out) |->
        addr_out[13:1] == 13'h0000) else $error("upper address driven in host mode");
    chk_full_addr: assert property (!host_mode_out && !$past(host_mode_out) &&
        !$past(reset_in) |-> addr_out == $past(core_addr_in)) else $error("address wrong");
    chk_host_low_data: assert property (host_mode_out && $past(host_mode_out) |->
        data_oe_n_out[7:0] == 8'hFF) else $error("low data pins driven in host mode");
    chk_byte_msb_addr: assert property (!host_mode_out && !$past(host_mode_out) &&
        $past(core_byte_in) && !$past(reset_in) |-> data_out[23:16] == $past(core_byte_hi_in)
        && data_oe_n_out[23:16] == 8'h00) else $error("byte address missing on data MSBs");
    chk_flag_dir: assert property (!$past(reset_in) |->
        prog_flag_oe_n_out == ~$past(flag_dir_in)) else $error("flag enable wrong");
    chk_ack_host_only: assert property (!host_port_ack_n_out |-> host_mode_out)
        else $error("host acknowledge in full memory mode");
    chk_level_irq: assert property (!$past(reset_in) && !$past(reset_in, 2) &&
        !$past(prog_flag_in[5], 2) && $past(interrupt_mask_bits_in[1]) &&
        $past(interrupt_mask_bits_in[1], 2) |-> irq_req_out[1]) else $error("level irq lost");
    chk_irq_masked: assert property (irq_req_out[1] |->
        $past(interrupt_mask_bits_in[1])) else $error("masked irq raised");
    chk_bus_grant: assert property (!$past(reset_in) && !$past(bus_request_n_in) &&
        $past(core_bus_idle_in) |-> !bus_grant_n_out) else $error("bus grant missing");
    chk_pd_ack: assert property (!$past(reset_in) && !$past(power_down_request_n_in) &&
        $past(core_pd_done_in) |-> power_down_ack_out) else $error("power-down ack missing");
endmodule

bind bmpm_pin_mux bmpm_pin_mux_assertions u_bmpm_pin_mux_assertions (.*);

// >>> tb/bmpm_far_model.sv
// Far-side model: external memory on the data pins and the host bus wires
`timescale 1ns/10ps
module bmpm_far_model (
    input  wire logic [0:0]  mclk_in,        // Processor clock
    input  wire logic [23:0] data_out,       // Device data drive
    input  wire logic [23:0] data_oe_n,      // Low = device drives
    input  wire logic [15:0] host_bus_out,   // Device host bus drive
    input  wire logic        host_bus_oe_n,  // Low = device drives
    input  wire logic        host_drv_en,    // Host processor drives bus
    input  wire logic [15:0] host_drv_val,   // Host processor bus value
    output logic      [23:0] data_in,        // Resolved data pins
    output logic      [15:0] host_bus_in     // Resolved host bus
);
    logic [23:0] mem_r = 24'h000000;  // Memory word last written
    logic [15:0] last_r = 16'h0000;   // Last level seen on host bus
    // Memory captures every bit the device drives
    always @(posedge mclk_in) begin
        mem_r  <= (data_out & ~data_oe_n) | (mem_r & data_oe_n);
        last_r <= host_bus_in;
    end
    // Memory answers on pins the device leaves free
    assign data_in = (data_out & ~data_oe_n) | (mem_r & data_oe_n);
    // Device, host, else a floating bus showing the inverse of its last level
    assign host_bus_in = !host_bus_oe_n ? host_bus_out :
                         host_drv_en ? host_drv_val : ~last_r;
endmodule

// >>> tb/boot_mode_pin_mux_tb_top.sv
// Self-checking testbench for the boot mode pin multiplexer
`timescale 1ns/10ps
module boot_mode_pin_mux_tb_top;
    // ************
    // Signals
    // ************
    logic mclk_in, reset_in, core_write_in, core_byte_in, host_write_strobe_n_in;
    logic host_read_strobe_n_in, host_addr_latch_in, host_port_select_n_in, host_ready_in;
    logic irq_el_edge_in, sport_b_irq_mode_in, sp_rfs_n_in, sp_tfs_n_in, sp_dr_in, core_dt_in;
    logic core_flag_output_in, bus_request_n_in, core_bus_idle_in, power_down_request_n_in;
    logic core_pd_done_in, host_addr_data_bus_oe_n_out, host_port_ack_n_out, host_wr_out;
    logic host_rd_out, sp_dt_out, flag_input_out, sp_rfs_core_out, sp_tfs_core_out;
    logic sp_dr_core_out, bus_grant_n_out, bus_grant_hung_n_out, power_down_ack_out;
    logic host_mode_out, host_drv_en;
    logic [13:0] core_addr_in, addr_out;
    logic [23:0] core_wdata_in, core_rdata_out, data_out, data_oe_n_out, data_in;
    logic [15:0] host_addr_data_bus_in, host_addr_data_bus_out, host_rdata_in, host_addr_out;
    logic [15:0] host_wdata_out, host_drv_val;
    logic [7:0]  core_byte_hi_in, prog_flag_in, flag_dir_in, flag_val_in, prog_flag_out;
    logic [7:0]  prog_flag_oe_n_out, flag_read_out, ext_flag;
    logic [5:0]  interrupt_mask_bits_in, irq_clear_in, irq_req_out;
    logic [1:0]  sp_irq_edge_in;
    int          miscompares = 0;  // Mismatches seen
    int          cmp_count = 0;    // Comparisons made

    // Flag wires: device drive where enabled, else the outside level
    assign prog_flag_in = (prog_flag_oe_n_out & ext_flag) | (~prog_flag_oe_n_out & prog_flag_out);

    bmpm_pin_mux u_bmpm_pin_mux (.*);
    bmpm_far_model u_bmpm_far_model (.mclk_in(mclk_in), .data_out(data_out),
        .data_oe_n(data_oe_n_out), .host_bus_out(host_addr_data_bus_out),
        .host_bus_oe_n(host_addr_data_bus_oe_n_out), .host_drv_en(host_drv_en),
        .host_drv_val(host_drv_val), .data_in(data_in), .host_bus_in(host_addr_data_bus_in));

    // Clock at 100 MHz
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // ************
    // Helpers
    // ************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic do_reset(input logic strap);
        ext_flag = strap ? 8'hFF : 8'hFB;  // Host strap sits on flag pin 2
        reset_in = 1'b1;
        cyc(16);
        reset_in = 1'b0;
        cyc(3);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ************
    // Scenarios
    // ************
    task automatic t_full_mem();
        do_reset(1'b0);
        chk(host_mode_out, 0);
        {core_addr_in, core_wdata_in, core_write_in} = {14'h2A5C, 24'hA5C3F0, 1'b1};
        cyc(1);
        chk(addr_out, 14'h2A5C);
        chk({data_out, data_oe_n_out[7:0]}, {24'hA5C3F0, 8'h00});
        {core_byte_in, core_byte_hi_in} = {1'b1, 8'h5A};
        cyc(1);
        chk({data_out[23:16], data_oe_n_out[23:16]}, 16'h5A00);
        {core_byte_in, core_write_in} = 2'b00;
        cyc(2);
        chk(core_rdata_out, 24'h5AC3F0);
        {host_port_select_n_in, host_write_strobe_n_in, host_ready_in} = 3'b001;
        cyc(2);
        chk(host_port_ack_n_out, 1);
        {host_port_select_n_in, host_write_strobe_n_in} = 2'b11;
    endtask
    task automatic t_flags();
        {flag_dir_in, flag_val_in, ext_flag} = {8'h03, 8'h02, 8'hB5};
        cyc(2);
        chk(flag_read_out, 8'hB6);
        chk(prog_flag_oe_n_out, 8'hFC);
        {flag_dir_in, ext_flag} = {8'h00, 8'hFF};
        cyc(2);
    endtask
    task automatic t_irq();
        {interrupt_mask_bits_in, ext_flag[5]} = {6'h02, 1'b0};
        cyc(2);
        chk(irq_req_out, 6'h02);
        interrupt_mask_bits_in = 6'h00;
        cyc(2);
        chk(irq_req_out, 6'h00);
        {ext_flag[5], interrupt_mask_bits_in, ext_flag[4]} = {1'b1, 6'h3F, 1'b0};
        cyc(1);
        ext_flag[4] = 1'b1;
        cyc(2);
        chk(irq_req_out[0], 1);
        irq_clear_in = 6'h01;
        cyc(1);
        irq_clear_in = 6'h00;
        cyc(2);
        chk(irq_req_out[0], 0);
        {irq_el_edge_in, ext_flag[7]} = 2'b10;
        cyc(1);
        ext_flag[7] = 1'b1;
        cyc(2);
        chk(irq_req_out[3], 1);
        {flag_dir_in, flag_val_in, irq_clear_in} = {8'h40, 8'h00, 6'h08};
        cyc(3);
        chk(irq_req_out[3:2], 2'b01);
        {flag_dir_in, irq_clear_in} = {8'h00, 6'h00};
        cyc(3);
        chk(irq_req_out[2], 0);
    endtask
    task automatic t_serial();
        {sport_b_irq_mode_in, core_dt_in, core_flag_output_in, sp_dr_in, sp_tfs_n_in} = 5'b01010;
        cyc(1);
        chk({sp_dt_out, sp_dr_core_out, flag_input_out, sp_tfs_core_out}, 4'b1100);
        sport_b_irq_mode_in = 1'b1;
        cyc(1);
        chk({sp_dt_out, flag_input_out, sp_dr_core_out, sp_tfs_core_out}, 4'b0101);
        sp_rfs_n_in = 1'b0;
        cyc(2);
        chk(irq_req_out[4], 1);
        {sp_rfs_n_in, sport_b_irq_mode_in, sp_tfs_n_in} = 3'b001;
        cyc(3);
        chk({irq_req_out[4], sp_dt_out, sp_rfs_core_out}, 3'b010);
    endtask
    task automatic t_bus_pd();
        {bus_request_n_in, core_bus_idle_in} = 2'b01;
        cyc(1);
        chk(bus_grant_n_out, 0);
        core_bus_idle_in = 1'b0;
        cyc(1);
        chk(bus_grant_hung_n_out, 0);
        {bus_request_n_in, core_bus_idle_in} = 2'b11;
        {power_down_request_n_in, core_pd_done_in} = 2'b01;
        cyc(2);
        chk({bus_grant_n_out, power_down_ack_out}, 2'b11);
        {power_down_request_n_in, core_pd_done_in} = 2'b10;
        cyc(1);
        chk(power_down_ack_out, 0);
    endtask
    task automatic t_host();
        do_reset(1'b1);
        chk(host_mode_out, 1);
        {core_addr_in, core_wdata_in, core_write_in} = {14'h3FFF, 24'hABCDEF, 1'b1};
        cyc(1);
        chk(addr_out, 14'h0001);
        chk({data_out[23:8], data_oe_n_out}, {16'hABCD, 24'h0000FF});
        core_write_in = 1'b0;
        {host_port_select_n_in, host_addr_latch_in, host_drv_en, host_drv_val} =
            {2'b01, 1'b1, 16'h1234};
        cyc(1);
        chk(host_addr_out, 16'h1234);
        {host_addr_latch_in, host_write_strobe_n_in, host_drv_val} = {2'b00, 16'hBEEF};
        cyc(1);
        chk({host_wr_out, host_wdata_out, host_port_ack_n_out}, {1'b1, 16'hBEEF, 1'b0});
        cyc(1);
        chk(host_wr_out, 0);
        {host_write_strobe_n_in, host_drv_en} = 2'b10;
        cyc(1);
        chk(host_port_ack_n_out, 1);
        {host_read_strobe_n_in, host_rdata_in} = {1'b0, 16'hC0DE};
        cyc(1);
        chk({host_rd_out, host_addr_data_bus_oe_n_out, host_addr_data_bus_out}, 18'h2C0DE);
        {host_read_strobe_n_in, host_port_select_n_in, ext_flag} = {2'b11, 8'hFB};
        cyc(2);
        chk(host_mode_out, 1);
    endtask

    // ************
    // Main sequence and watchdog
    // ************
    initial begin
        {reset_in, core_write_in, core_byte_in, host_addr_latch_in, host_ready_in} = 5'b10000;
        {host_write_strobe_n_in, host_read_strobe_n_in, host_port_select_n_in} = 3'b111;
        {irq_el_edge_in, sport_b_irq_mode_in, sp_rfs_n_in, sp_tfs_n_in, sp_dr_in} = 5'b00110;
        {core_dt_in, core_flag_output_in, bus_request_n_in, core_bus_idle_in} = 4'b0010;
        {power_down_request_n_in, core_pd_done_in, host_drv_en} = 3'b100;
        {core_addr_in, core_wdata_in, core_byte_hi_in, host_rdata_in} = '0;
        {flag_dir_in, flag_val_in, ext_flag, host_drv_val} = {16'h0000, 8'hFF, 16'h0000};
        {interrupt_mask_bits_in, irq_clear_in, sp_irq_edge_in} = '0;
        t_full_mem();
        t_flags();
        t_irq();
        t_serial();
        t_bus_pd();
        t_host();
        report_and_stop();
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule
